//--- csu_pkg.sv
// Constants shared by the coprocessor indexed store unit and its decoder
package csu_pkg;
  // Instruction field positions, bit 31 here is big-endian bit 0
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int SEL_MSB = 25;
  localparam int SEL_LSB = 21;
  localparam int BAS_MSB = 20;
  localparam int BAS_LSB = 16;
  localparam int XO_MSB  = 10;
  localparam int XO_LSB  = 1;
  // Opcode values
  localparam logic [5:0] OPC_PRIMARY = 6'h1F;
  localparam logic [9:0] XO_WORD     = 10'h0C7;
  localparam logic [9:0] XO_DOUBLE   = 10'h187;
  localparam logic [9:0] XO_QUAD     = 10'h0E7;
  // Index of the last 32-bit beat per form
  localparam logic [1:0] LAST_WORD   = 2'h0;
  localparam logic [1:0] LAST_DOUBLE = 2'h1;
  localparam logic [1:0] LAST_QUAD   = 2'h3;
  // Address alignment and core register layout
  localparam logic [1:0]  ALIGN_ZERO  = 2'h0;
  localparam logic [27:0] INST_RSVD   = 28'h0000000;
  localparam logic [31:0] SPR_NONE    = 32'h00000000;
  localparam logic [4:0]  REG_ZERO    = 5'h00;
  typedef enum logic [1:0] {CSU_IDLE, CSU_XLATE, CSU_FETCH, CSU_WRITE} csu_state_e;
endpackage : csu_pkg

//--- csu_decode.sv
// Decoder for the word, double and quad indexed coprocessor stores
`timescale 1ns/1ns
module csu_decode
  import csu_pkg::*;
(
  // Instruction
  input  wire logic [31:0] instr_i,
  // Decoded fields
  output logic             is_store_o,
  output logic [1:0]       last_beat_o,
  output logic [4:0]       sel_o,
  output logic             base_zero_o
);
  logic [9:0] xo;

  // Field split; the reserved low bit is not examined, its use is undefined
  always_comb
  begin
    xo          = instr_i[XO_MSB:XO_LSB];
    sel_o       = instr_i[SEL_MSB:SEL_LSB];
    base_zero_o = (instr_i[BAS_MSB:BAS_LSB] == REG_ZERO);
    is_store_o  = 1'b0;
    last_beat_o = LAST_WORD;
    if (instr_i[OPC_MSB:OPC_LSB] == OPC_PRIMARY)
    begin
      unique case (xo)
        XO_WORD:   is_store_o = 1'b1;
        XO_DOUBLE:
        begin
          is_store_o  = 1'b1;
          last_beat_o = LAST_DOUBLE;
        end
        XO_QUAD:
        begin
          is_store_o  = 1'b1;
          last_beat_o = LAST_QUAD;
        end
        default:   is_store_o = 1'b0;
      endcase
    end
  end
endmodule : csu_decode

//--- csu_store_unit.sv
// Processor-side execution of indexed coprocessor stores and identity registers
`timescale 1ns/1ns
// Function
// - Decode word store, opcode 31, extended 199
// - Decode double store, extended opcode 391
// - Decode quad store, extended opcode 231
// - Address is base plus index, base zero
// - Word: aligned address, one coprocessor word stored
// - Double: two words at address, address+4
// - Quad: four words at +0,+4,+8,+12
// - Zone-protected relocated store raises storage exception
// - No-access zones block user mode only
// - Read-only zones block both modes
// - Missing translation raises translation-miss exception
// - Reserved bits set: no program exception
// - Read-only core version register via move-from
// - Instance register: reserved high, user low nibble
module csu_store_unit
  import csu_pkg::*;
#(
  parameter logic [31:0] VERSION_ID   = 32'h00A5C001, // Arbitrary value
  parameter logic [3:0]  INSTANCE_ID  = 4'h5,         // Arbitrary value
  parameter logic [9:0]  SPRN_VERSION = 10'h100,
  parameter logic [9:0]  SPRN_INST    = 10'h101
)
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Instruction issue with operand values
  input  wire logic        issue_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] base_data_i,
  input  wire logic [31:0] index_data_i,
  input  wire logic        user_mode_i,
  input  wire logic        coproc_enable_i,
  // Translation and zone check for mem_addr_o
  input  wire logic        data_reloc_i,
  input  wire logic        tlb_hit_i,
  input  wire logic        zone_no_access_i,
  input  wire logic        zone_read_only_i,
  // Coprocessor data beats
  input  wire logic        cop_valid_i,
  input  wire logic [31:0] cop_data_i,
  // Memory write
  input  wire logic        mem_ack_i,
  // Special register read
  input  wire logic        spr_rd_i,
  input  wire logic [9:0]  spr_num_i,
  // Status and memory outputs
  output logic             busy_o,
  output logic             xlate_req_o,
  output logic             cop_req_o,
  output logic [4:0]       cop_sel_o,
  output logic [1:0]       cop_beat_o,
  output logic             mem_we_o,
  output logic [31:0]      mem_addr_o,
  output logic [31:0]      mem_data_o,
  output logic             done_o,
  output logic             dsi_o,
  output logic             tlb_miss_o,
  // Special register answer
  output logic             spr_ack_o,
  output logic [31:0]      spr_data_o
);
  logic        dec_store;
  logic [1:0]  dec_last;
  logic [4:0]  dec_sel;
  logic        dec_base_zero;
  logic        start;
  logic [31:0] ea_sum;
  csu_state_e  state, next_state;
  logic [31:0] ea, next_ea;
  logic [1:0]  last_beat, next_last_beat;
  logic        next_busy, next_xlate_req, next_cop_req, next_mem_we;
  logic [4:0]  next_cop_sel;
  logic [1:0]  next_cop_beat;
  logic [31:0] next_mem_addr, next_mem_data;
  logic        next_done, next_dsi, next_tlb_miss;
  logic        next_spr_ack;
  logic [31:0] next_spr_data;

  csu_decode u_decode (
    .instr_i     (instr_i),
    .is_store_o  (dec_store),
    .last_beat_o (dec_last),
    .sel_o       (dec_sel),
    .base_zero_o (dec_base_zero)
  );

  // Coprocessor stores only run once software has enabled the unit
  assign start  = issue_i && dec_store && coproc_enable_i && (state == CSU_IDLE);
  // Base register 0 reads as zero, low two bits cleared for word alignment
  assign ea_sum = (dec_base_zero ? SPR_NONE : base_data_i) + index_data_i;

  // Store sequencer: translate, then fetch and write one word per beat
  always_comb
  begin
    next_state     = state;
    next_ea        = ea;
    next_last_beat = last_beat;
    next_busy      = busy_o;
    next_xlate_req = 1'b0;
    next_cop_req   = cop_req_o;
    next_cop_sel   = cop_sel_o;
    next_cop_beat  = cop_beat_o;
    next_mem_we    = mem_we_o;
    next_mem_addr  = mem_addr_o;
    next_mem_data  = mem_data_o;
    next_done      = 1'b0;
    next_dsi       = 1'b0;
    next_tlb_miss  = 1'b0;
    unique case (state)
      CSU_IDLE:
      begin
        if (start)
        begin
          next_state     = CSU_XLATE;
          next_ea        = {ea_sum[31:2], ALIGN_ZERO};
          next_mem_addr  = {ea_sum[31:2], ALIGN_ZERO};
          next_last_beat = dec_last;
          next_cop_sel   = dec_sel;
          next_cop_beat  = LAST_WORD;
          next_busy      = 1'b1;
          next_xlate_req = 1'b1;
        end
      end
      CSU_XLATE:
      begin
        // Translation result outranks zone check, which needs the entry
        if (data_reloc_i && !tlb_hit_i)
        begin
          next_state    = CSU_IDLE;
          next_tlb_miss = 1'b1;
          next_busy     = 1'b0;
        end
        else if (data_reloc_i && (zone_read_only_i || (zone_no_access_i && user_mode_i)))
        begin
          next_state = CSU_IDLE;
          next_dsi   = 1'b1;
          next_busy  = 1'b0;
        end
        else
        begin
          next_state   = CSU_FETCH;
          next_cop_req = 1'b1;
        end
      end
      CSU_FETCH:
      begin
        if (cop_valid_i)
        begin
          next_state    = CSU_WRITE;
          next_cop_req  = 1'b0;
          next_mem_data = cop_data_i;
          next_mem_we   = 1'b1;
          next_mem_addr = ea + {28'h0000000, cop_beat_o, ALIGN_ZERO};
        end
      end
      CSU_WRITE:
      begin
        if (mem_ack_i)
        begin
          next_mem_we = 1'b0;
          if (cop_beat_o == last_beat)
          begin
            // No general register is written back by these forms
            next_state = CSU_IDLE;
            next_done  = 1'b1;
            next_busy  = 1'b0;
          end
          else
          begin
            next_state    = CSU_FETCH;
            next_cop_beat = cop_beat_o + 2'h1;
            next_cop_req  = 1'b1;
          end
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state       <= CSU_IDLE;
      ea          <= SPR_NONE;
      last_beat   <= LAST_WORD;
      busy_o      <= 1'b0;
      xlate_req_o <= 1'b0;
      cop_req_o   <= 1'b0;
      cop_sel_o   <= REG_ZERO;
      cop_beat_o  <= LAST_WORD;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= SPR_NONE;
      mem_data_o  <= SPR_NONE;
      done_o      <= 1'b0;
      dsi_o       <= 1'b0;
      tlb_miss_o  <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      ea          <= next_ea;
      last_beat   <= next_last_beat;
      busy_o      <= next_busy;
      xlate_req_o <= next_xlate_req;
      cop_req_o   <= next_cop_req;
      cop_sel_o   <= next_cop_sel;
      cop_beat_o  <= next_cop_beat;
      mem_we_o    <= next_mem_we;
      mem_addr_o  <= next_mem_addr;
      mem_data_o  <= next_mem_data;
      done_o      <= next_done;
      dsi_o       <= next_dsi;
      tlb_miss_o  <= next_tlb_miss;
    end
  end

  // Identity registers are constants; unknown numbers read as zero
  always_comb
  begin
    next_spr_ack  = spr_rd_i;
    next_spr_data = SPR_NONE;
    if (spr_rd_i && (spr_num_i == SPRN_VERSION))
      next_spr_data = VERSION_ID;
    else if (spr_rd_i && (spr_num_i == SPRN_INST))
      next_spr_data = {INST_RSVD, INSTANCE_ID};
  end

  // Special register answer registers
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      spr_ack_o  <= 1'b0;
      spr_data_o <= SPR_NONE;
    end
    else
    begin
      spr_ack_o  <= next_spr_ack;
      spr_data_o <= next_spr_data;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic dsi_cond;
  assign dsi_cond = data_reloc_i && (zone_read_only_i || (zone_no_access_i && user_mode_i));
  sequence xlate_pass_s;
    (state == CSU_XLATE) && !(data_reloc_i && !tlb_hit_i) && !dsi_cond;
  endsequence
  sequence first_write_s;
    mem_we_o && (mem_addr_o == ea);
  endsequence

  word_decode_a: assert property (start && (instr_i[XO_MSB:XO_LSB] == XO_WORD)
    |=> last_beat == LAST_WORD) else $error("word form beat count wrong");
  dbl_decode_a: assert property (start && (instr_i[XO_MSB:XO_LSB] == XO_DOUBLE)
    |=> last_beat == LAST_DOUBLE) else $error("double form beat count wrong");
  quad_decode_a: assert property (start && (instr_i[XO_MSB:XO_LSB] == XO_QUAD)
    |=> last_beat == LAST_QUAD) else $error("quad form beat count wrong");
  ea_form_a: assert property (start |=> xlate_req_o &&
    mem_addr_o == {$past(ea_sum[31:2]), ALIGN_ZERO}) else $error("effective address wrong");
  beat_addr_a: assert property (mem_we_o |->
    mem_addr_o == ea + {28'h0000000, cop_beat_o, ALIGN_ZERO}) else $error("beat address wrong");
  data_pass_a: assert property ((state == CSU_FETCH) && cop_valid_i |=> mem_we_o &&
    mem_data_o == $past(cop_data_i)) else $error("coprocessor word not stored");
  first_beat_a: assert property (xlate_pass_s ##[1:16]
    ((state == CSU_FETCH) && cop_valid_i && (cop_beat_o == LAST_WORD)) |=> first_write_s)
    else $error("first beat not at aligned address");
  zone_block_a: assert property ((state == CSU_XLATE) && tlb_hit_i && dsi_cond |=>
    dsi_o && !mem_we_o && state == CSU_IDLE) else $error("zone violation not raised");
  priv_pass_a: assert property ((state == CSU_XLATE) && data_reloc_i && tlb_hit_i &&
    zone_no_access_i && !zone_read_only_i && !user_mode_i |=> !dsi_o && cop_req_o)
    else $error("privileged store blocked");
  ro_block_a: assert property ((state == CSU_XLATE) && data_reloc_i && tlb_hit_i &&
    zone_read_only_i |=> dsi_o) else $error("read-only zone not blocked");
  tlb_miss_a: assert property ((state == CSU_XLATE) && data_reloc_i && !tlb_hit_i |=>
    tlb_miss_o && !dsi_o) else $error("translation miss not raised");
  inst_read_a: assert property (spr_rd_i && spr_num_i == SPRN_INST |=> spr_ack_o &&
    spr_data_o == {INST_RSVD, INSTANCE_ID}) else $error("instance register wrong");
  ver_read_a: assert property (spr_rd_i && spr_num_i == SPRN_VERSION |=>
    spr_data_o == VERSION_ID) else $error("version register wrong");
endmodule : csu_store_unit

//--- csu_cop_model.sv
// Fabric coprocessor model answering each beat request with a tagged word
`timescale 1ns/1ns
module csu_cop_model
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Beat request and stall setting
  input  wire logic        req_i,
  input  wire logic [4:0]  sel_i,
  input  wire logic [1:0]  beat_i,
  input  wire logic [3:0]  delay_i,
  // Word answer
  output logic             valid_o,
  output logic [31:0]      data_o
);
  logic [3:0] wait_cnt;

  // Answer after delay_i cycles; idle data flips so a stale word never matches
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      valid_o  <= 1'b0;
      wait_cnt <= 4'h0;
      data_o   <= 32'h00000000;
    end
    else if (req_i && !valid_o && wait_cnt >= delay_i)
    begin
      valid_o  <= 1'b1;
      wait_cnt <= 4'h0;
      data_o   <= {3'h5, sel_i, beat_i, 22'h2A5A5};
    end
    else
    begin
      valid_o  <= 1'b0;
      wait_cnt <= req_i ? wait_cnt + 4'h1 : 4'h0;
      data_o   <= ~data_o;
    end
  end
endmodule : csu_cop_model

//--- test_csu_store_unit.sv
// Self-checking bench for the coprocessor indexed store unit
`timescale 1ns/1ns
module test_csu_store_unit
  import csu_pkg::*;
;
  localparam logic [31:0] VER  = 32'h13572468; // Arbitrary value
  localparam logic [3:0]  INST = 4'h9;         // Arbitrary value
  logic clock_i, rst_i = 1'b1, issue_i = 1'b0, user_mode_i = 1'b0, en = 1'b1;
  logic data_reloc_i = 1'b0, tlb_hit_i = 1'b0, zone_no_access_i = 1'b0;
  logic zone_read_only_i = 1'b0, mem_ack_i = 1'b0, spr_rd_i = 1'b0, rsv = 1'b0;
  logic [31:0] instr_i = 32'h0, base_data_i = 32'h0, index_data_i = 32'h0;
  logic [9:0]  spr_num_i = 10'h000;
  logic [3:0]  cop_delay = 4'h0, mem_stall = 4'h0, mem_cnt = 4'h0;
  logic busy_o, xlate_req_o, cop_req_o, mem_we_o, done_o, dsi_o, tlb_miss_o;
  logic spr_ack_o, cop_valid_i;
  logic [4:0]  cop_sel_o;
  logic [1:0]  cop_beat_o;
  logic [31:0] mem_addr_o, mem_data_o, spr_data_o, cop_data_i;
  logic [31:0] wr_addr[$], wr_data[$];
  int fails = 0, cmp_count = 0;

  csu_store_unit #(.VERSION_ID(VER), .INSTANCE_ID(INST)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .issue_i(issue_i), .instr_i(instr_i),
    .base_data_i(base_data_i), .index_data_i(index_data_i), .user_mode_i(user_mode_i),
    .coproc_enable_i(en), .data_reloc_i(data_reloc_i), .tlb_hit_i(tlb_hit_i),
    .zone_no_access_i(zone_no_access_i), .zone_read_only_i(zone_read_only_i),
    .cop_valid_i(cop_valid_i), .cop_data_i(cop_data_i), .mem_ack_i(mem_ack_i),
    .spr_rd_i(spr_rd_i), .spr_num_i(spr_num_i), .busy_o(busy_o), .xlate_req_o(xlate_req_o),
    .cop_req_o(cop_req_o), .cop_sel_o(cop_sel_o), .cop_beat_o(cop_beat_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
    .done_o(done_o), .dsi_o(dsi_o), .tlb_miss_o(tlb_miss_o), .spr_ack_o(spr_ack_o),
    .spr_data_o(spr_data_o));

  csu_cop_model cop (.clock_i(clock_i), .rst_i(rst_i), .req_i(cop_req_o), .sel_i(cop_sel_o),
    .beat_i(cop_beat_o), .delay_i(cop_delay), .valid_o(cop_valid_i), .data_o(cop_data_i));

  // Clock at 25 MHz
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Memory side stalls mem_stall cycles, then logs each accepted write
  always @(posedge clock_i)
  begin
    if (mem_we_o && mem_ack_i)
    begin
      wr_addr.push_back(mem_addr_o);
      wr_data.push_back(mem_data_o);
    end
    mem_cnt   <= (mem_we_o && !mem_ack_i) ? mem_cnt + 4'h1 : 4'h0;
    mem_ack_i <= mem_we_o && !mem_ack_i && mem_cnt >= mem_stall;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // Read one special register; the answer stands the cycle after the request
  task automatic spr(input logic [9:0] num, input logic [31:0] exp);
    spr_rd_i  <= 1'b1;
    spr_num_i <= num;
    @(posedge clock_i);
    spr_rd_i <= 1'b0;
    @(posedge clock_i);
    chk(32'(spr_ack_o), 32'h1);
    chk(spr_data_o, exp);
  endtask : spr

  // One store; kind 0 completes, 1 storage fault, 2 translation miss, 3 ignored
  task automatic op(input logic [9:0] xo, input logic [4:0] bfld, input logic [31:0] base,
                    input logic [31:0] idx, input logic [4:0] flags, input logic [1:0] kind);
    int n;
    int t;
    int xl;
    logic [31:0] ea;
    logic [2:0]  seen;
    n = (xo === XO_QUAD) ? 4 : (xo === XO_DOUBLE) ? 2 : 1;
    ea = ((bfld === 5'h00) ? 32'h0 : base) + idx;
    ea[1:0] = 2'h0;
    seen = 3'h0;
    xl = 0;
    wr_addr.delete();
    wr_data.delete();
    {user_mode_i, data_reloc_i, tlb_hit_i, zone_no_access_i, zone_read_only_i} <= flags;
    instr_i      <= {6'h1F, 5'h0B, bfld, 5'h0C, xo, rsv};
    base_data_i  <= base;
    index_data_i <= idx;
    issue_i      <= 1'b1;
    @(posedge clock_i);
    issue_i <= 1'b0;
    for (t = 0; t < ((kind == 2'h3) ? 10 : 200) && seen === 3'h0; t++)
    begin
      @(posedge clock_i);
      xl += int'(xlate_req_o);
      seen = {done_o, dsi_o, tlb_miss_o};
    end
    if (kind != 2'h3 && seen === 3'h0)
    begin
      fails++;
      test_done;
    end
    chk(32'(seen), 32'({kind == 2'h0, kind == 2'h1, kind == 2'h2}));
    chk(32'(busy_o), 32'h0);
    chk(32'(xl), (kind == 2'h3) ? 0 : 1);
    chk(32'(wr_addr.size()), (kind == 2'h0) ? n : 0);
    foreach (wr_addr[k])
    begin
      chk(wr_addr[k], ea + 32'(4 * k));
      chk(wr_data[k], {3'h5, 5'h0B, 2'(k), 22'h2A5A5});
    end
  endtask : op

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock_i);
    chk(32'({busy_o, mem_we_o, cop_req_o, done_o}), 32'h0);
    rst_i <= 1'b0;
    @(posedge clock_i);
    spr(10'h100, VER);
    spr(10'h101, {28'h0000000, INST});
    spr(10'h1FF, 32'h0);
    op(XO_WORD, 5'h00, 32'hFFFF0000, 32'h00001007, 5'h00, 2'h0);
    cop_delay <= 4'h3;
    mem_stall <= 4'h2;
    op(XO_DOUBLE, 5'h03, 32'h10000001, 32'h00000102, 5'h00, 2'h0);
    op(XO_QUAD, 5'h03, 32'h7FFFFFF0, 32'h0000001E, 5'h00, 2'h0);
    op(XO_QUAD, 5'h03, 32'h00000040, 32'h0, 5'h08, 2'h2);
    op(XO_WORD, 5'h03, 32'h00000040, 32'h0, 5'h1E, 2'h1);
    op(XO_WORD, 5'h03, 32'h00000040, 32'h0, 5'h0E, 2'h0);
    op(XO_DOUBLE, 5'h03, 32'h00000040, 32'h0, 5'h0D, 2'h1);
    op(XO_WORD, 5'h03, 32'h00000040, 32'h0, 5'h13, 2'h0);
    rsv = 1'b1;
    op(XO_DOUBLE, 5'h03, 32'h00000080, 32'h4, 5'h00, 2'h0);
    rsv = 1'b0;
    op(10'h2C7, 5'h03, 32'h00000080, 32'h4, 5'h00, 2'h3);
    en <= 1'b0;
    op(XO_WORD, 5'h03, 32'h00000080, 32'h4, 5'h00, 2'h3);
    // Software re-enables the unit; the next word store runs to completion
    en <= 1'b1;
    op(XO_WORD, 5'h03, 32'h00000080, 32'h4, 5'h00, 2'h0);
    test_done;
  end
endmodule : test_csu_store_unit
